/* hw/rcl_top.sv */
// regulator enable, setting select, ramp and over-current control
`timescale 1ns/1ps
`include "rcl_consts.svh"
module rcl_top
  import rcl_pkg::*;
#(
  parameter int OC_EVT_CYC = `RCL_OC_EVT_MS * `RCL_CLK_KHZ,
  parameter int OC_SD_CYC = `RCL_OC_SD_MS * `RCL_CLK_KHZ
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // power mode
  input wire logic powerActive,
  input wire logic powerSleepMode,
  input wire logic resetMode,
  // serial writes of settings, enables, selects
  input wire logic wrSetValid,
  input wire logic [2:0] wrSetReg,
  input wire logic wrSetWhich,
  input wire rcl_code_t wrSetCode,
  input wire logic wrSetSleep,
  input wire logic wrEnValid,
  input wire logic [2:0] wrEnReg,
  input wire logic wrEnVal,
  input wire logic wrSelValid,
  input wire logic [2:0] wrSelReg,
  input wire logic wrSelVal,
  // sequencer requests
  input wire logic seqEnValid,
  input wire logic [2:0] seqEnReg,
  input wire logic seqEnVal,
  input wire logic seqSelValid,
  input wire logic [2:0] seqSelReg,
  input wire logic seqSelVal,
  // pins and pin configuration
  input wire logic [2:0] gpiPin,
  input wire logic [2:0] gpiActiveHigh,
  input wire logic [15:0] enPinMap,
  input wire logic [15:0] selPinMap,
  input wire logic [7:0] selAuto,
  input wire logic [2:0] pinDriveOut,
  input wire logic [2:0] pinDriveEn,
  input wire logic terminationSensePinEnable,
  input wire logic terminationRefPinEnable,
  // converter configuration and sense
  input wire logic [1:0] slewRate,
  input wire logic converterSoftStart,
  input wire logic converterActiveDischarge,
  input wire logic [7:0] converterCurrentLimit,
  input wire logic [7:0] convModeField,
  input wire logic [3:0] convOverLimit,
  // linear configuration and sense
  input wire logic linAlwaysOn,
  input wire logic overcurrentShutdownEnable,
  input wire logic [3:0] linearPulldownDisable,
  input wire logic [3:0] linLimitCmp,
  input wire logic [3:0] linOverVolt,
  // pin outputs
  output logic [2:0] pinEvent_r,
  output logic [2:0] pinOut_r,
  output logic [2:0] pinOe_r,
  // converter outputs
  output logic [3:0] convPowerOn_r,
  output logic [31:0] convCode_r,
  output logic [51:0] convTargetMv_r,
  output logic [7:0] convOpMode_r,
  output logic [3:0] convSlowStart_r,
  output logic [7:0] convCurrentLimit_r,
  output logic [3:0] convDutyLimit_r,
  output logic voltageRampDoneEvent_r,
  // linear outputs
  output logic [3:0] linEnable_r,
  output logic [31:0] linCode_r,
  output logic [3:0] linSleep_r,
  output logic [3:0] linearLimitStatus_r,
  output logic [3:0] linDischarge_r,
  output logic linearOvercurrentEvent_r
);
  localparam int NREG = `RCL_NUM_CONV + `RCL_NUM_LIN;
  localparam int NSYNC = `RCL_NUM_PIN + 12;
  localparam int OCW = $clog2(OC_SD_CYC + 1);
  localparam logic [OCW-1:0] OC_EVT_M1 = OCW'(OC_EVT_CYC - 1);
  localparam logic [OCW-1:0] OC_SD_M1 = OCW'(OC_SD_CYC - 1);
  localparam logic [OCW-1:0] OC_SD_C = OCW'(OC_SD_CYC);
  // step time is a least time, so round up
  localparam int SLEW_CYC = (`RCL_SLEW_BASE_NS * `RCL_CLK_MHZ + 999) / 1000;

  generate
    if (OC_EVT_CYC < 1 || OC_SD_CYC <= OC_EVT_CYC || SLEW_CYC > 31) begin : g_bad
      $error("rcl_top: over-current or slew counts out of range");
    end
  endgenerate

  // ------------------------------------------------------------
  // synchronisers and pin edges
  // ------------------------------------------------------------
  logic [NSYNC-1:0] syncA_r, syncB_r; // two-stage sync chain
  logic [2:0] pinPrev_r; // last active pin level
  logic [2:0] pinAct, pinRise, pinFall, analogMask;
  logic [3:0] limSyn, ovSyn, convLimSyn;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // pins start at their passive level, so no false edge follows reset
      syncA_r <= {{(NSYNC - `RCL_NUM_PIN){1'b0}}, ~gpiActiveHigh};
      syncB_r <= {{(NSYNC - `RCL_NUM_PIN){1'b0}}, ~gpiActiveHigh};
      pinPrev_r <= '0;
    end else if (clkEn) begin
      syncA_r <= {convOverLimit, linOverVolt, linLimitCmp, gpiPin};
      syncB_r <= syncA_r;
      pinPrev_r <= pinAct;
    end
  end

  assign limSyn = syncB_r[6:3];
  assign ovSyn = syncB_r[10:7];
  assign convLimSyn = syncB_r[14:11];
  // analog pins lose sensing, edges and driving
  assign analogMask = {1'b0, terminationRefPinEnable, terminationSensePinEnable};
  assign pinAct = ~(syncB_r[2:0] ^ gpiActiveHigh);
  assign pinRise = pinAct & ~pinPrev_r & ~analogMask;
  assign pinFall = ~pinAct & pinPrev_r & ~analogMask;

  // which pin edge a 2-bit map points at
  function automatic logic pick(input rcl_pinsel_t m, input logic [2:0] v);
    logic r;
    r = 1'b0;
    if (m != `RCL_PIN_NONE) begin
      r = v[m - 2'h1];
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // enables, selects and stored settings
  // ------------------------------------------------------------
  logic [NREG-1:0] regEn_r, regEn_nxt; // 0..3 converters, 4..7 linears
  logic [NREG-1:0] regSel_r, regSel_nxt; // setting select bits
  rcl_code_t [NREG-1:0][1:0] setCode_r, setCode_nxt; // two codes each
  logic [NREG-1:0][1:0] setSleep_r, setSleep_nxt; // sleep link per setting
  logic [NREG-1:0] ocSdAll, effSel, actSleep;
  rcl_code_t [NREG-1:0] actCode;
  logic [3:0] ocSdHit, ocEvtHit;

  assign ocSdAll = {ocSdHit, 4'h0};

  // later assignments win: pin edge over sequencer, write over all
  always_comb begin
    regEn_nxt = regEn_r;
    regSel_nxt = regSel_r;
    setCode_nxt = setCode_r;
    setSleep_nxt = setSleep_r;
    for (int i = 0; i < NREG; i++) begin
      if (ocSdAll[i]) begin
        regEn_nxt[i] = 1'b0;
      end
      // a pin-owned function ignores the sequencer
      if (seqEnValid && seqEnReg == 3'(i) && enPinMap[2*i +: 2] == `RCL_PIN_NONE) begin
        regEn_nxt[i] = seqEnVal;
      end
      if (pick(enPinMap[2*i +: 2], pinRise)) begin
        regEn_nxt[i] = 1'b1;
      end
      if (pick(enPinMap[2*i +: 2], pinFall)) begin
        regEn_nxt[i] = 1'b0;
      end
      // re-enable after shutdown comes only from these sources
      if (wrEnValid && wrEnReg == 3'(i)) begin
        regEn_nxt[i] = wrEnVal;
      end
      if (seqSelValid && seqSelReg == 3'(i) && selPinMap[2*i +: 2] == `RCL_PIN_NONE) begin
        regSel_nxt[i] = seqSelVal;
      end
      if (pick(selPinMap[2*i +: 2], pinRise)) begin
        regSel_nxt[i] = 1'b1;
      end
      if (pick(selPinMap[2*i +: 2], pinFall)) begin
        regSel_nxt[i] = 1'b0;
      end
      if (wrSelValid && wrSelReg == 3'(i)) begin
        regSel_nxt[i] = wrSelVal;
      end
    end
    // serial setting writes only land in the active mode
    if (wrSetValid && powerActive) begin
      setCode_nxt[wrSetReg][wrSetWhich] = wrSetCode;
      setSleep_nxt[wrSetReg][wrSetWhich] = wrSetSleep;
    end
  end

  // register only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regEn_r <= '0;
      regSel_r <= '0;
      setCode_r <= '0;
      setSleep_r <= '0;
    end else if (clkEn) begin
      regEn_r <= regEn_nxt;
      regSel_r <= regSel_nxt;
      setCode_r <= setCode_nxt;
      setSleep_r <= setSleep_nxt;
    end
  end

  // active setting per regulator
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      effSel[i] = selAuto[i] ? powerSleepMode : regSel_r[i];
      actCode[i] = setCode_r[i][effSel[i]];
      actSleep[i] = setSleep_r[i][effSel[i]];
    end
  end

  // ------------------------------------------------------------
  // over-current timers and slew tick
  // ------------------------------------------------------------
  logic [3:0][OCW-1:0] ocCnt_r, ocCnt_nxt; // asserted-time counters
  logic [7:0] slewCnt_r, slewCnt_nxt; // step interval counter
  logic [7:0] slewIv;
  logic slewTick;

  assign slewIv = 8'(SLEW_CYC) << slewRate;
  assign slewTick = (slewCnt_r >= slewIv - 8'h01);

  always_comb begin
    ocCnt_nxt = ocCnt_r;
    for (int j = 0; j < 4; j++) begin
      ocEvtHit[j] = limSyn[j] && ocCnt_r[j] == OC_EVT_M1;
      ocSdHit[j] = limSyn[j] && ocCnt_r[j] == OC_SD_M1 && overcurrentShutdownEnable;
      if (!limSyn[j]) begin
        ocCnt_nxt[j] = '0;
      end else if (ocCnt_r[j] != OC_SD_C) begin
        ocCnt_nxt[j] = ocCnt_r[j] + OCW'(1);
      end
    end
    slewCnt_nxt = slewTick ? 8'h00 : slewCnt_r + 8'h01;
  end

  // register only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ocCnt_r <= '0;
      slewCnt_r <= '0;
    end else if (clkEn) begin
      ocCnt_r <= ocCnt_nxt;
      slewCnt_r <= slewCnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // converter ramps
  // ------------------------------------------------------------
  logic [3:0] convOn, rampDone, convPrev_r;
  logic [31:0] rampCode;
  logic allDonePrev_r; // held high so reset gives no event

  assign convOn = regEn_r[3:0] & {4{~resetMode}};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ramp
      rcl_ramp_if rb ();
      // off without discharge drops at once, with it ramps to zero
      assign rb.tick = slewTick;
      assign rb.jump = !convOn[g] && !converterActiveDischarge;
      assign rb.target = convOn[g] ? actCode[g] : `RCL_CODE_RST;
      assign rampCode[8*g +: 8] = rb.code;
      assign rampDone[g] = rb.done;
      rcl_ramp u_ramp (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .rp(rb)
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinEvent_r <= '0;
      pinOut_r <= '0;
      pinOe_r <= '0;
      convPowerOn_r <= '0;
      convCode_r <= '0;
      convTargetMv_r <= '0;
      convOpMode_r <= '0;
      convSlowStart_r <= '0;
      convCurrentLimit_r <= '0;
      convDutyLimit_r <= '0;
      convPrev_r <= '0;
      voltageRampDoneEvent_r <= 1'b0;
      allDonePrev_r <= 1'b1;
      linEnable_r <= '0;
      linCode_r <= '0;
      linSleep_r <= '0;
      linearLimitStatus_r <= '0;
      linDischarge_r <= '0;
      linearOvercurrentEvent_r <= 1'b0;
    end else if (clkEn) begin
      pinEvent_r <= pinRise;
      pinOut_r <= pinDriveOut & ~analogMask;
      pinOe_r <= pinDriveEn & ~analogMask;
      convCode_r <= rampCode;
      convCurrentLimit_r <= converterCurrentLimit;
      // limit caps duty only, converter keeps running
      convDutyLimit_r <= convLimSyn & convOn;
      convPrev_r <= convOn;
      allDonePrev_r <= &rampDone;
      voltageRampDoneEvent_r <= (&rampDone) && !allDonePrev_r;
      linearOvercurrentEvent_r <= |ocEvtHit;
      linearLimitStatus_r <= limSyn;
      linDischarge_r <= ovSyn & ~linearPulldownDisable;
      for (int k = 0; k < 4; k++) begin
        convPowerOn_r[k] <= convOn[k] || rampCode[8*k +: 8] != `RCL_CODE_RST;
        convTargetMv_r[13*k +: 13] <= 13'(actCode[k]) * ((k == `RCL_WIDE_CONV) ?
          13'(`RCL_STEP_WIDE_MV) : 13'(`RCL_STEP_STD_MV));
        convOpMode_r[2*k +: 2] <= actSleep[k] ? `RCL_MODE_PFM : convModeField[2*k +: 2];
        if (convOn[k] && !convPrev_r[k]) begin
          convSlowStart_r[k] <= converterSoftStart;
        end
        linEnable_r[k] <= regEn_r[4+k] && (!resetMode || (k == 0 && linAlwaysOn));
        linCode_r[8*k +: 8] <= actCode[4+k];
        linSleep_r[k] <= actSleep[4+k];
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_analogMute;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && terminationSensePinEnable) |=> !pinOe_r[0] && !pinEvent_r[0];
  endproperty
  a_analogMute: assert property (p_analogMute) else $error("analog pin still digital");

  property p_writeGate;
    @(posedge clk) disable iff (sys_rst)
    !(clkEn && wrSetValid && powerActive) |=> $stable(setCode_r) && $stable(setSleep_r);
  endproperty
  a_writeGate: assert property (p_writeGate) else $error("setting changed outside write");

  property p_ocEvent;
    @(posedge clk) disable iff (sys_rst)
    linearOvercurrentEvent_r |-> (ocCnt_r[0] == OCW'(OC_EVT_CYC)) ||
      (ocCnt_r[1] == OCW'(OC_EVT_CYC)) || (ocCnt_r[2] == OCW'(OC_EVT_CYC)) ||
      (ocCnt_r[3] == OCW'(OC_EVT_CYC));
  endproperty
  a_ocEvent: assert property (p_ocEvent) else $error("over-current event at wrong time");

  property p_ocRestart;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && !limSyn[0]) |=> ocCnt_r[0] == '0;
  endproperty
  a_ocRestart: assert property (p_ocRestart) else $error("limit timer did not restart");

  property p_ocShut;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && ocSdHit[0] && !(wrEnValid && wrEnReg == 3'h4) && !pinRise[0] && !pinRise[1]
      && !pinRise[2] && !(seqEnValid && seqEnReg == 3'h4)) |=> !regEn_r[4] ##1 !linEnable_r[0];
  endproperty
  a_ocShut: assert property (p_ocShut) else $error("over-current shutdown missed");

  property p_alwaysOn;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && resetMode) |=> !linEnable_r[1] && !linEnable_r[2] && !linEnable_r[3]
      && (linEnable_r[0] == ($past(regEn_r[4]) && $past(linAlwaysOn)));
  endproperty
  a_alwaysOn: assert property (p_alwaysOn) else $error("reset mode enables wrong");

  property p_discharge;
    @(posedge clk) disable iff (sys_rst)
    clkEn |=> linDischarge_r == ($past(ovSyn) & ~$past(linearPulldownDisable));
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge load wrong");

  property p_sleepForce;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && actSleep[0]) |=> convOpMode_r[1:0] == `RCL_MODE_PFM;
  endproperty
  a_sleepForce: assert property (p_sleepForce) else $error("sleep link not forcing pfm");

  property p_readyEvt;
    @(posedge clk) disable iff (sys_rst)
    voltageRampDoneEvent_r |-> allDonePrev_r && !$past(allDonePrev_r);
  endproperty
  a_readyEvt: assert property (p_readyEvt) else $error("ready event without completion");

  property p_writeWins;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && wrEnValid && wrEnReg == 3'h5) |=> regEn_r[5] == $past(wrEnVal);
  endproperty
  a_writeWins: assert property (p_writeWins) else $error("enable write lost");
endmodule

/* hw/rcl_consts.svh */
// constants shared by the regulator control logic files
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define RCL_CLK_KHZ 40000
`define RCL_CLK_MHZ 40
`define RCL_OC_EVT_MS 10
`define RCL_OC_SD_MS 200
`define RCL_SLEW_BASE_NS 500
// ------------------------------------------------------------
// sizes, steps and encodings
// ------------------------------------------------------------
`define RCL_NUM_CONV 4
`define RCL_NUM_LIN 4
`define RCL_NUM_PIN 3
`define RCL_STEP_STD_MV 10
`define RCL_STEP_WIDE_MV 20
`define RCL_WIDE_CONV 2
`define RCL_CODE_RST 8'h00
`define RCL_MODE_AUTO 2'h0
`define RCL_MODE_PWM 2'h1
`define RCL_MODE_PFM 2'h2
`define RCL_PIN_NONE 2'h0
`endif

/* hw/rcl_pkg.sv */
// types shared by the regulator control logic
package rcl_pkg;
  typedef logic [7:0] rcl_code_t;
  typedef logic [1:0] rcl_mode_t;
  typedef logic [1:0] rcl_pinsel_t;
  typedef logic [12:0] rcl_mv_t;
endpackage

/* hw/rcl_ramp_if.sv */
// carrier between the control core and one converter ramp
`timescale 1ns/1ps
interface rcl_ramp_if;
  import rcl_pkg::*;
  logic tick; // shared slew interval pulse
  logic jump; // load target at once
  rcl_code_t target; // code to reach
  rcl_code_t code; // present ramped code
  logic done; // code equals target
  modport ctrl (output tick, output jump, output target, input code, input done);
  modport ramp (input tick, input jump, input target, output code, output done);
endinterface

/* hw/rcl_ramp.sv */
// one converter code ramp, one step per slew tick
`timescale 1ns/1ps
`include "rcl_consts.svh"
module rcl_ramp
  import rcl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // control side
  rcl_ramp_if.ramp rp
);
  rcl_code_t code_r; // ramped code
  rcl_code_t code_nxt; // next code

  // ------------------------------------------------------------
  // stepping
  // ------------------------------------------------------------
  // single code steps keep in-rush bounded
  always_comb begin
    code_nxt = code_r;
    if (rp.jump) begin
      code_nxt = rp.target;
    end else if (rp.tick && code_r < rp.target) begin
      code_nxt = code_r + 8'h01;
    end else if (rp.tick && code_r > rp.target) begin
      code_nxt = code_r - 8'h01;
    end
  end

  // register only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_r <= `RCL_CODE_RST;
    end else if (clkEn) begin
      code_r <= code_nxt;
    end
  end

  assign rp.code = code_r;
  assign rp.done = (code_r == rp.target);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_rampStep;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && rp.tick && !rp.jump && code_r != rp.target) |=>
      (code_r == $past(code_r) + 8'h01) || (code_r == $past(code_r) - 8'h01);
  endproperty
  a_rampStep: assert property (p_rampStep) else $error("ramp step not one code");

  property p_rampHold;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && !rp.tick && !rp.jump) |=> $stable(code_r);
  endproperty
  a_rampHold: assert property (p_rampHold) else $error("ramp moved without tick");
endmodule

/* testbench/rcl_host_pins.sv */
// host side model: drives the three input pins of the regulator block
`timescale 1ns/1ps
module rcl_host_pins (
  // pin levels seen by the device
  output logic [2:0] gpiPin
);
  // -------------------------------------------
  // pin state
  // -------------------------------------------
  initial gpiPin = 3'h0; // all pins passive at start
  // change one pin level; the host drives pins with no relation to the clock
  task automatic setPin(input int idx, input logic v);
    gpiPin[idx] = v;
  endtask
endmodule

/* testbench/test_rcl_top.sv */
// self-checking bench for the regulator control logic top
`timescale 1ns/1ps
module test_rcl_top
  import rcl_pkg::*;
;
  // -------------------------------------------
  // design inputs and outputs
  // -------------------------------------------
  logic clk, sys_rst, clkEn, powerActive, powerSleepMode, resetMode;
  logic wrSetValid, wrSetWhich, wrSetSleep, wrEnValid, wrEnVal, wrSelValid, wrSelVal;
  logic seqEnValid, seqEnVal, seqSelValid, seqSelVal, converterSoftStart;
  logic terminationSensePinEnable, terminationRefPinEnable, converterActiveDischarge;
  logic linAlwaysOn, overcurrentShutdownEnable, voltageRampDoneEvent_r;
  logic linearOvercurrentEvent_r;
  logic [2:0] wrSetReg, wrEnReg, wrSelReg, seqEnReg, seqSelReg, gpiPin, gpiActiveHigh;
  logic [2:0] pinDriveOut, pinDriveEn, pinEvent_r, pinOut_r, pinOe_r;
  rcl_code_t wrSetCode;
  logic [15:0] enPinMap, selPinMap;
  logic [7:0] selAuto, converterCurrentLimit, convModeField, convOpMode_r, convCurrentLimit_r;
  logic [1:0] slewRate;
  logic [3:0] convOverLimit, linearPulldownDisable, linLimitCmp, linOverVolt, convPowerOn_r;
  logic [3:0] convSlowStart_r, convDutyLimit_r, linEnable_r, linSleep_r, linearLimitStatus_r;
  logic [3:0] linDischarge_r;
  logic [31:0] convCode_r, linCode_r;
  logic [51:0] convTargetMv_r;
  int fails = 0, num_checks = 0, ocCnt = 0, rdyCnt = 0, ev0 = 0, ev2 = 0, badStep = 0;
  logic [7:0] prevCode = 8'h00, frz;
  // short over-current spans keep the run brief
  rcl_top #(.OC_EVT_CYC(20), .OC_SD_CYC(60)) i_dut (.*);
  rcl_host_pins i_host (.gpiPin(gpiPin));
  // -------------------------------------------
  // clock, pulse monitors
  // -------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count one-cycle event pulses and watch the ramp never skips a code
  always @(posedge clk) begin
    ocCnt += linearOvercurrentEvent_r;
    rdyCnt += voltageRampDoneEvent_r;
    ev0 += pinEvent_r[0];
    ev2 += pinEvent_r[2];
    if (convCode_r[7:0] > prevCode + 8'h01 || prevCode > convCode_r[7:0] + 8'h01) badStep++;
    prevCode = convCode_r[7:0];
  end
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // enable write, one valid pulse
  task automatic wrEn(input logic [2:0] r, input logic v);
    wrEnValid = 1'b1;
    wrEnReg = r;
    wrEnVal = v;
    step(1);
    wrEnValid = 1'b0;
    step(1);
  endtask
  task automatic wrSel(input logic [2:0] r, input logic v);
    wrSelValid = 1'b1;
    wrSelReg = r;
    wrSelVal = v;
    step(1);
    wrSelValid = 1'b0;
    step(1);
  endtask
  task automatic wrSet(input logic [2:0] r, input logic w, input rcl_code_t c, input logic s);
    wrSetValid = 1'b1;
    wrSetReg = r;
    wrSetWhich = w;
    wrSetCode = c;
    wrSetSleep = s;
    step(1);
    wrSetValid = 1'b0;
    step(1);
  endtask
  // sequencer request: sel picks select over enable
  task automatic seqReq(input logic sel, input logic [2:0] r, input logic v);
    {seqEnReg, seqEnVal, seqSelReg, seqSelVal} = {r, v, r, v};
    seqEnValid = !sel;
    seqSelValid = sel;
    step(1);
    {seqEnValid, seqSelValid} = 2'h0;
    step(1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far beyond the sequence length
  initial begin
    #(20000 * 25);
    fails++;
    finish_test();
  end
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial begin
    {sys_rst, clkEn, powerActive, powerSleepMode, resetMode} = 5'h1c;
    {wrSetValid, wrSetWhich, wrSetSleep, wrEnValid, wrEnVal, wrSelValid, wrSelVal} = 7'h00;
    {seqEnValid, seqEnVal, seqSelValid, seqSelVal, converterSoftStart} = 5'h00;
    {terminationSensePinEnable, terminationRefPinEnable, converterActiveDischarge} = 3'h0;
    {linAlwaysOn, overcurrentShutdownEnable} = 2'h1;
    {wrSetReg, wrEnReg, wrSelReg, seqEnReg, seqSelReg} = 15'h0000;
    {gpiActiveHigh, pinDriveOut, pinDriveEn, wrSetCode} = {3'h7, 3'h0, 3'h0, 8'h00};
    {enPinMap, selPinMap, selAuto, converterCurrentLimit, convModeField} = 56'h0c000000000000;
    {slewRate, convOverLimit, linearPulldownDisable, linLimitCmp, linOverVolt} = 18'h00000;
    step(4);
    sys_rst = 1'b0;
    check("linEnable", 4'h0, linEnable_r);
    // two settings, second one carries the sleep link
    wrSet(3'h4, 1'b0, 8'h30, 1'b0);
    wrSet(3'h4, 1'b1, 8'h50, 1'b1);
    wrEn(3'h4, 1'b1);
    step(2);
    check("linEnable", 4'h1, linEnable_r);
    check("linCode", 32'h30, linCode_r[7:0]);
    check("linSleep", 4'h0, linSleep_r);
    wrSel(3'h4, 1'b1);
    step(2);
    check("linCode", 32'h50, linCode_r[7:0]);
    check("linSleep", 4'h1, linSleep_r);
    powerActive = 1'b0;
    wrSet(3'h4, 1'b1, 8'h60, 1'b1);
    step(2);
    check("linCode", 32'h50, linCode_r[7:0]);
    powerActive = 1'b1;
    // pin 2 runs linear 1 enable; pin 0 is in analog use
    terminationSensePinEnable = 1'b1;
    i_host.setPin(2, 1'b1);
    i_host.setPin(0, 1'b1);
    step(8);
    check("linEnable", 4'h3, linEnable_r);
    check("pinEvent2", 32'h1, ev2);
    check("pinEvent0", 32'h0, ev0);
    i_host.setPin(2, 1'b0);
    step(8);
    check("linEnable", 4'h1, linEnable_r);
    wrEn(3'h5, 1'b1);
    step(2);
    check("linEnable", 4'h3, linEnable_r);
    // two short limit spells, counter must restart between them
    repeat (2) begin
      linLimitCmp = 4'h1;
      step(15);
      linLimitCmp = 4'h0;
      step(4);
    end
    check("ocEvent", 32'h0, ocCnt);
    linLimitCmp = 4'h1;
    step(4);
    check("limitStatus", 4'h1, linearLimitStatus_r);
    step(25);
    check("ocEvent", 32'h1, ocCnt);
    step(45);
    check("linEnable", 4'h2, linEnable_r);
    linLimitCmp = 4'h0;
    step(10);
    check("linEnable", 4'h2, linEnable_r);
    wrEn(3'h4, 1'b1);
    step(2);
    check("linEnable", 4'h3, linEnable_r);
    // converter ramp, plain and wide step converters
    wrSet(3'h0, 1'b0, 8'h05, 1'b0);
    wrSet(3'h2, 1'b0, 8'h05, 1'b0);
    converterSoftStart = 1'b1;
    {converterCurrentLimit, convModeField} = 16'h1b01;
    wrEn(3'h0, 1'b1);
    step(2);
    check("mv0", 32'h32, convTargetMv_r[12:0]);
    check("mv2", 32'h64, convTargetMv_r[38:26]);
    check("slowStart", 32'h1, convSlowStart_r);
    check("curLimit", 32'h1b, convCurrentLimit_r);
    check("opMode", 32'h01, convOpMode_r);
    for (int i = 0; i < 400 && rdyCnt == 0; i++) step(1);
    check("code0", 32'h05, convCode_r[7:0]);
    check("rampStep", 32'h0, badStep);
    check("rampDone", 32'h1, rdyCnt);
    check("powerOn", 32'h1, convPowerOn_r);
    // limit only caps duty; sleep link on the second setting forces pfm
    convOverLimit = 4'h1;
    wrSet(3'h0, 1'b1, 8'h05, 1'b1);
    wrSel(3'h0, 1'b1);
    step(2);
    check("dutyLimit", 32'h1, convDutyLimit_r);
    check("powerOnLim", 32'h1, convPowerOn_r);
    check("opMode", 32'h02, convOpMode_r);
    convOverLimit = 4'h0;
    // switched off with discharge: ramps down, holds while clock enable is low
    converterActiveDischarge = 1'b1;
    wrEn(3'h0, 1'b0);
    step(30);
    check("powerOnDis", 32'h1, convPowerOn_r);
    clkEn = 1'b0;
    frz = convCode_r[7:0];
    step(50);
    check("frozen", frz, convCode_r[7:0]);
    clkEn = 1'b1;
    for (int i = 0; i < 400 && rdyCnt < 2; i++) step(1);
    check("code0", 32'h00, convCode_r[7:0]);
    check("powerOnOff", 32'h0, convPowerOn_r);
    check("rampDone", 32'h2, rdyCnt);
    check("rampStep", 32'h0, badStep);
    // discharge load, masked pin drive, sequencer, select pin, auto select
    {linOverVolt, linearPulldownDisable} = 8'h32;
    {pinDriveOut, pinDriveEn} = 6'h3f;
    step(4);
    check("discharge", 32'h1, linDischarge_r);
    check("pinOe", 32'h6, pinOe_r);
    check("pinOut", 32'h6, pinOut_r);
    seqReq(1'b0, 3'h6, 1'b1);
    seqReq(1'b0, 3'h5, 1'b0);
    seqReq(1'b1, 3'h4, 1'b0);
    step(2);
    check("linEnable", 32'h7, linEnable_r);
    check("linCode", 32'h30, linCode_r[7:0]);
    selPinMap = 16'h0200;
    i_host.setPin(1, 1'b1);
    step(8);
    check("linCode", 32'h50, linCode_r[7:0]);
    i_host.setPin(1, 1'b0);
    step(8);
    check("linCode", 32'h30, linCode_r[7:0]);
    {selAuto, powerSleepMode} = 9'h021;
    step(2);
    check("linCode", 32'h50, linCode_r[7:0]);
    {linAlwaysOn, resetMode} = 2'h3;
    step(2);
    check("linEnable", 32'h1, linEnable_r);
    finish_test();
  end
endmodule
